//--- design/flt_pkg.sv
package flt_pkg;

   // Serial command word
   localparam int WORD_BITS = 18;
   localparam int FREQ_BITS = 14;
   localparam logic [4:0] WORD_LEN = 5'h12;
   localparam logic [4:0] CNT_MAX = 5'h1F;

   // Command word layout, first received bit in bit 0
   typedef struct packed {
      logic [13:0] freq;   // Wanted oscillator frequency, 14 MSBs
      logic [1:0] rate;    // Tuning counter decrement rate
      logic [1:0] reverse; // Direction reversal
   } flt_word_t;

   localparam flt_word_t WORD_RESET = '{freq: 14'h0000, rate: 2'h0, reverse: 2'h0};
   localparam logic [1:0] REVERSE_ON = 2'h3;

   // Frequency counter length masks per window
   localparam logic [13:0] MASK_14 = 14'h3FFF;
   localparam logic [13:0] MASK_12 = 14'h0FFF;
   localparam logic [13:0] MASK_11 = 14'h07FF;
   localparam logic [13:0] MASK_10 = 14'h03FF;
   localparam logic [1:0] WSEL_14 = 2'h0;
   localparam logic [1:0] WSEL_12 = 2'h1;
   localparam logic [1:0] WSEL_11 = 2'h2;

   // Holding range: one count either side of zero
   localparam logic [13:0] HOLD_COUNT = 14'h0001;
   localparam logic [13:0] ONE_COUNT = 14'h0001;

   // Timing
   localparam int CLK_MHZ = 50;
   localparam int MEAS_TIME_US = 4096;
   localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
   localparam int RATE_US_0 = 1;
   localparam int RATE_US_1 = 2;
   localparam int RATE_US_2 = 4;
   localparam int RATE_US_3 = 8;
   localparam logic [15:0] RATE_DIV_0 = 16'(RATE_US_0 * CLK_MHZ);
   localparam logic [15:0] RATE_DIV_1 = 16'(RATE_US_1 * CLK_MHZ);
   localparam logic [15:0] RATE_DIV_2 = 16'(RATE_US_2 * CLK_MHZ);
   localparam logic [15:0] RATE_DIV_3 = 16'(RATE_US_3 * CLK_MHZ);
   localparam logic [15:0] RATE_STEP = 16'h0001;

   // Synchroniser lane order
   localparam int SYN_N = 7;
   localparam int SYN_SCLK = 0;
   localparam int SYN_SDATA = 1;
   localparam int SYN_SEN = 2;
   localparam int SYN_OSC = 3;
   localparam int SYN_HOLD = 4;
   localparam int SYN_WSA = 5;
   localparam int SYN_WSB = 6;

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_MEAS = 3'b010,
      S_CORR = 3'b100
   } flt_state_t;

endpackage

//--- design/flt_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for a group of asynchronous levels
module flt_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule // flt_sync

//--- design/flt_tuning.sv
// Summary of operation
// (R1) Host sends 18-bit serial words; device shifts each into its shift register.
// (R2) Shortly after a complete valid word, copy shift register into holding latch.
// (R3) Preset frequency counter from the 14 most significant latched bits.
// (R4) Prescaled oscillator cycles decrement the counter only during 4096 us window.
// (R5) At window end: passed zero too high, nonzero too low, zero correct.
// (R6) Residual count loads tuning counter, decremented to zero by clock pulses.
// (R7) Raise or lower pulse output stands exactly while tuning counter runs.
// (R8) Zero residual gives no correction pulse and drives AFC enable high.
// (R9) AFC enable stays high while error stays within holding range.
// (R10) Window selects shorten counter to 12, 11 or 10 bits.
// (R11) Word bits three and four choose one of four decrement rates.
// (R12) Word bits one and two can invert the correction direction.
// (R13) Hold high suppresses correction pulses and freezes AFC enable.
// (R14) Measure-then-correct repeats continuously, restarting when a new word latches.
// (R15) Both window selects low means full 14-bit window; others 12, 11, 10.
`timescale 1ns/1ps

module flt_tuning #(
   parameter int MEAS_CYC = flt_pkg::MEAS_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic bus_clk_i,
   input wire logic bus_data_i,
   input wire logic bus_enable_i,
   input wire logic prescaled_osc_in_i,
   input wire logic hold_i,
   input wire logic window_select_a_i,
   input wire logic window_select_b_i,
   output logic freq_raise_pulse_o,
   output logic freq_lower_pulse_o,
   output logic afc_enable_out_o
);

   logic [flt_pkg::SYN_N-1:0] syn;
   logic sclk_q, sen_q, osc_q;
   logic sclk_rise, sen_rise, sen_fall, osc_rise;
   logic [17:0] shift_word;
   logic [4:0] bit_cnt;
   logic word_valid;
   flt_pkg::flt_word_t latch_word;
   logic new_word;
   flt_pkg::flt_state_t state;
   logic start_meas, meas_end;
   logic [17:0] meas_cnt;
   logic [13:0] mask, fcount, residual, tcount;
   logic passed, err_high, raise_dir, hold_s;
   logic [15:0] rate_cnt, rate_div;
   logic rate_tick;

   // All pins but clock and reset are foreign to ref_clk_i and pass two flops first
   flt_sync #(.WIDTH(flt_pkg::SYN_N)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .async_i({window_select_b_i, window_select_a_i, hold_i, prescaled_osc_in_i,
                bus_enable_i, bus_data_i, bus_clk_i}),
      .sync_o(syn)
   );

   assign hold_s = syn[flt_pkg::SYN_HOLD];

   // Edge detectors on synchronised copies only
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_q <= 1'b0;
         sen_q <= 1'b0;
         osc_q <= 1'b0;
      end else begin
         sclk_q <= syn[flt_pkg::SYN_SCLK];
         sen_q <= syn[flt_pkg::SYN_SEN];
         osc_q <= syn[flt_pkg::SYN_OSC];
      end
   end

   assign sclk_rise = syn[flt_pkg::SYN_SCLK] & ~sclk_q;
   assign sen_rise = syn[flt_pkg::SYN_SEN] & ~sen_q;
   assign sen_fall = ~syn[flt_pkg::SYN_SEN] & sen_q;
   assign osc_rise = syn[flt_pkg::SYN_OSC] & ~osc_q;

   // Serial shift: first bit ends in bit 0; count saturates so long words fail
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         shift_word <= 18'h00000;
         bit_cnt <= 5'h00;
      end else if (sen_rise) begin
         bit_cnt <= 5'h00;
      end else if (syn[flt_pkg::SYN_SEN] && sclk_rise) begin
         shift_word <= {syn[flt_pkg::SYN_SDATA], shift_word[17:1]}; // [R1]
         if (bit_cnt != flt_pkg::CNT_MAX) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // Word judged valid only with exactly 18 clocks inside the frame
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         word_valid <= 1'b0;
      end else begin
         word_valid <= sen_fall && (bit_cnt == flt_pkg::WORD_LEN); // [R2]
      end
   end

   // Holding latch, loaded one cycle after the valid check
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         latch_word <= flt_pkg::WORD_RESET;
         new_word <= 1'b0;
      end else begin
         new_word <= word_valid;
         if (word_valid) begin
            latch_word <= flt_pkg::flt_word_t'(shift_word); // [R2]
         end
      end
   end

   // Counter length from window selects
   always_comb begin
      unique case ({syn[flt_pkg::SYN_WSB], syn[flt_pkg::SYN_WSA]})
         flt_pkg::WSEL_14: mask = flt_pkg::MASK_14; // [R15]
         flt_pkg::WSEL_12: mask = flt_pkg::MASK_12; // [R10]
         flt_pkg::WSEL_11: mask = flt_pkg::MASK_11; // [R10]
         default: mask = flt_pkg::MASK_10; // [R10]
      endcase
   end

   // Restart on a fresh word, or after each correction ends
   assign start_meas = new_word || (state == flt_pkg::S_CORR && tcount == 14'h0000); // [R14]
   // A window cut short by a fresh word is discarded, not classified
   assign meas_end = (state == flt_pkg::S_MEAS) && (meas_cnt == 18'(MEAS_CYC - 1))
                     && !new_word;

   // Sequencer
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= flt_pkg::S_IDLE;
      end else if (start_meas) begin
         state <= flt_pkg::S_MEAS;
      end else if (meas_end) begin
         state <= flt_pkg::S_CORR;
      end
   end

   // Measuring window timer
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meas_cnt <= 18'h00000;
      end else if (start_meas) begin
         meas_cnt <= 18'h00000;
      end else if (state == flt_pkg::S_MEAS) begin
         meas_cnt <= meas_cnt + 18'h00001;
      end
   end

   // Frequency counter wraps at the selected length; borrow marks too high
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fcount <= 14'h0000;
         passed <= 1'b0;
      end else if (start_meas) begin
         fcount <= latch_word.freq & mask; // [R3]
         passed <= 1'b0;
      end else if (state == flt_pkg::S_MEAS && osc_rise) begin
         if (fcount == 14'h0000) begin
            passed <= 1'b1; // [R5]
         end
         fcount <= (fcount - flt_pkg::ONE_COUNT) & mask; // [R4]
      end
   end

   // Size of error: negate the wrapped count when zero was passed
   assign residual = passed ? ((~fcount + flt_pkg::ONE_COUNT) & mask) : fcount; // [R6]

   // Decrement-rate divider picked by word bits three and four
   always_comb begin
      unique case (latch_word.rate)
         2'h0: rate_div = flt_pkg::RATE_DIV_0; // [R11]
         2'h1: rate_div = flt_pkg::RATE_DIV_1;
         2'h2: rate_div = flt_pkg::RATE_DIV_2;
         default: rate_div = flt_pkg::RATE_DIV_3;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rate_cnt <= 16'h0000;
         rate_tick <= 1'b0;
      end else if (meas_end) begin
         // Align the divider to the load so pulse length does not jitter
         rate_cnt <= 16'h0000; // [R7]
         rate_tick <= 1'b0;
      end else if (rate_cnt >= rate_div - flt_pkg::RATE_STEP) begin
         rate_cnt <= 16'h0000;
         rate_tick <= 1'b1;
      end else begin
         rate_cnt <= rate_cnt + flt_pkg::RATE_STEP;
         rate_tick <= 1'b0;
      end
   end

   // Tuning counter; frozen under hold so no correction is lost
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tcount <= 14'h0000;
         err_high <= 1'b0;
      end else if (meas_end) begin
         tcount <= residual; // [R6]
         err_high <= passed; // [R5]
      end else if (state == flt_pkg::S_CORR && rate_tick && !hold_s && tcount != 14'h0000) begin
         tcount <= tcount - flt_pkg::ONE_COUNT; // [R6]
      end
   end

   // Too low means raise, unless the word asks for reversal
   assign raise_dir = ~err_high ^ (latch_word.reverse == flt_pkg::REVERSE_ON); // [R12]

   // Pulse outputs stand while the tuning counter runs
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         freq_raise_pulse_o <= 1'b0;
         freq_lower_pulse_o <= 1'b0;
      end else begin
         freq_raise_pulse_o <= state == flt_pkg::S_CORR && tcount != 14'h0000
                               && !hold_s && raise_dir; // [R7] [R13]
         freq_lower_pulse_o <= state == flt_pkg::S_CORR && tcount != 14'h0000
                               && !hold_s && !raise_dir; // [R7] [R13]
      end
   end

   // AFC enable: set on zero error, kept inside holding range, frozen by hold
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         afc_enable_out_o <= 1'b0;
      end else if (meas_end && !hold_s) begin // [R13]
         if (residual == 14'h0000) begin
            afc_enable_out_o <= 1'b1; // [R8]
         end else if (residual > flt_pkg::HOLD_COUNT) begin
            afc_enable_out_o <= 1'b0; // [R9]
         end
      end
   end

   // Checks
   latch_copy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R2]
      word_valid |=> latch_word == $past(shift_word))
      else $error("latch did not take the shift register");

   preset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R3]
      start_meas |=> fcount == ($past(latch_word.freq) & $past(mask)))
      else $error("frequency counter preset wrong");

   count_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R4]
      (state != flt_pkg::S_MEAS && !start_meas) |=> $stable(fcount))
      else $error("frequency counter moved outside window");

   classify_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R5]
      meas_end |=> (err_high == $past(passed)) && (state == flt_pkg::S_CORR))
      else $error("error sign not captured at window end");

   residual_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R6]
      (meas_end && !passed) |=> tcount == $past(fcount))
      else $error("residual not loaded into tuning counter");

   pulse_run_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R7]
      (freq_raise_pulse_o || freq_lower_pulse_o) |->
         $past(tcount) != 14'h0000 && !(freq_raise_pulse_o && freq_lower_pulse_o))
      else $error("pulse without running tuning counter");

   afc_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R8]
      (meas_end && residual == 14'h0000 && !hold_s) |=> afc_enable_out_o ##1
         (!freq_raise_pulse_o && !freq_lower_pulse_o))
      else $error("zero error did not enable afc");

   hold_freeze_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R13]
      hold_s |=> !freq_raise_pulse_o && !freq_lower_pulse_o && $stable(afc_enable_out_o))
      else $error("hold did not freeze outputs");

   restart_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // [R14]
      (state == flt_pkg::S_CORR && tcount == 14'h0000) |=>
         state == flt_pkg::S_MEAS && meas_cnt == 18'h00000)
      else $error("measurement did not restart");

endmodule // flt_tuning

//--- tb/flt_host.sv
`timescale 1ns/1ps

// Host on the three-wire control bus; the bus clock stands still outside frames
module flt_host (
   output logic bus_clk_o,
   output logic bus_data_o,
   output logic bus_enable_o
);
   initial begin
      bus_clk_o = 1'b0;
      bus_data_o = 1'b0;
      bus_enable_o = 1'b0;
   end

   // First bit sent is word bit 0; each level lasts 80 ns, well over 3 clocks
   task automatic send(input logic [17:0] word, input int nbits);
      int i;
      bus_enable_o = 1'b1;
      #80;
      for (i = 0; i < nbits; i++) begin
         bus_data_o = word[i];
         #80;
         bus_clk_o = 1'b1;
         #80;
         bus_clk_o = 1'b0;
      end
      #80;
      bus_enable_o = 1'b0;
      // Released data line shows the inverse so a stale bit cannot pass as valid
      bus_data_o = ~bus_data_o;
      #160;
   endtask
endmodule // flt_host

//--- tb/flt_tuning_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t: got %0h expected %0h", $time, (a), (b)); end end

module flt_tuning_tb;
   localparam int MC = 200;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic bus_clk, bus_data, bus_en;
   logic osc = 1'b0;
   logic osc_on = 1'b0;
   logic hold = 1'b0;
   logic [1:0] wsel = 2'h0;
   logic raise, lower, afc, up, seen;
   int fails = 0;
   int check_count = 0;
   int seed = 71;
   int len, i, e;
   logic [13:0] f;
   logic [1:0] r, rv;

   always #10 ref_clk_i = ~ref_clk_i;

   // Oscillator of 10 clocks period, so a window holds about MC/10 counts
   always begin
      repeat (5) @(negedge ref_clk_i);
      osc = osc_on & ~osc;
   end

   flt_host host (.bus_clk_o(bus_clk), .bus_data_o(bus_data), .bus_enable_o(bus_en));

   flt_tuning #(.MEAS_CYC(MC)) dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .bus_clk_i(bus_clk), .bus_data_i(bus_data), .bus_enable_i(bus_en),
      .prescaled_osc_in_i(osc), .hold_i(hold), .window_select_a_i(wsel[0]),
      .window_select_b_i(wsel[1]), .freq_raise_pulse_o(raise),
      .freq_lower_pulse_o(lower), .afc_enable_out_o(afc));

   // Clocks per tuning count for a rate code
   function automatic int tick(input logic [1:0] rc);
      return flt_pkg::CLK_MHZ << rc;
   endfunction

   function automatic logic near(input int v, input int lo, input int hi);
      return (v >= lo) && (v <= hi);
   endfunction

   task automatic results();
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Next correction pulse: direction and length, every wait bounded
   task automatic meas(output logic u, output int n);
      int k;
      k = 0;
      n = 0;
      while ((raise | lower) !== 1'b0 && k < 9000) begin @(negedge ref_clk_i); k++; end
      while ((raise | lower) !== 1'b1 && k < 9000) begin @(negedge ref_clk_i); k++; end
      u = raise;
      while ((raise | lower) === 1'b1 && k < 9000) begin @(negedge ref_clk_i); k++; n++; end
      if (k >= 9000) begin
         fails++;
         results();
      end
   endtask

   task automatic quiet(output logic s);
      s = 1'b0;
      repeat (600) begin
         @(negedge ref_clk_i);
         s = s | raise | lower;
      end
   endtask

   task automatic wait_afc();
      int k;
      for (k = 0; k < 600 && afc !== 1'b1; k++) @(negedge ref_clk_i);
      if (afc !== 1'b1) begin
         fails++;
         results();
      end
   endtask

   initial begin
      repeat (5) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      // Every rate code first, then random words; oscillator stopped for exact counts
      for (i = 0; i < 8; i++) begin
         f = 14'(1 + ({$random(seed)} % 7));
         r = (i < 4) ? i[1:0] : 2'($random(seed));
         rv = (i == 0) ? flt_pkg::REVERSE_ON : 2'($random(seed));
         host.send({f, r, rv}, 18);
         meas(up, len);
         e = int'(f) * tick(r);
         `CHK(up, rv != flt_pkg::REVERSE_ON)
         `CHK(near(len, e - 1, e + 1), 1'b1)
         if (i == 0) begin
            meas(up, len);
            `CHK(near(len, e - 1, e + 1), 1'b1)
         end
      end
      // Live oscillator: too low then too high
      osc_on = 1'b1;
      host.send({14'h003C, 2'h0, 2'h0}, 18);
      meas(up, len);
      `CHK(up, 1'b1)
      `CHK(near(len, 37 * tick(2'h0), 43 * tick(2'h0)), 1'b1)
      host.send({14'h0005, 2'h0, 2'h0}, 18);
      meas(up, len);
      `CHK(up, 1'b0)
      `CHK(near(len, 12 * tick(2'h0), 18 * tick(2'h0)), 1'b1)
      osc_on = 1'b0;
      `CHK(afc, 1'b0)
      // Hold freezes a low enable and blocks pulses
      hold = 1'b1;
      host.send({14'h0000, 2'h0, 2'h0}, 18);
      quiet(seen);
      `CHK(seen, 1'b0)
      `CHK(afc, 1'b0)
      hold = 1'b0;
      wait_afc();
      `CHK(afc, 1'b1)
      // Short word is dropped
      host.send({14'h0005, 2'h0, 2'h0}, 17);
      quiet(seen);
      `CHK(seen, 1'b0)
      `CHK(afc, 1'b1)
      // One count stays inside the holding range, five does not
      host.send({14'h0001, 2'h0, 2'h0}, 18);
      meas(up, len);
      `CHK(afc, 1'b1)
      host.send({14'h0005, 2'h0, 2'h0}, 18);
      meas(up, len);
      `CHK(afc, 1'b0)
      // Shortened counters wrap the top bit away to zero
      for (i = 1; i < 4; i++) begin
         wsel = i[1:0];
         host.send({14'h1000 >> (i - 1), 2'h0, 2'h0}, 18);
         wait_afc();
         `CHK(afc, 1'b1)
         host.send({14'h0005, 2'h0, 2'h0}, 18);
         meas(up, len);
         `CHK(afc, 1'b0)
      end
      results();
   end
endmodule // flt_tuning_tb
